// ---- include/split_pwm_cfg.svh ----
// register offsets, field positions, reset values and divider masks of the split pwm timer
// assumes a 32-bit apb slave with byte addresses, one register per aligned word
`ifndef SPLIT_PWM_CFG_SVH
`define SPLIT_PWM_CFG_SVH

// byte offsets
`define OFS_CTRL 8'h00
`define OFS_OUTCFG 8'h04
`define OFS_LPER 8'h08
`define OFS_HPER 8'h0c
`define OFS_LCMP 8'h10
`define OFS_HCMP 8'h14
`define OFS_LOW_COUNT 8'h18
`define OFS_HIGH_COUNT 8'h1c
`define OFS_FLAGS 8'h20
`define OFS_MASK 8'h24
`define OFS_CMD 8'h28

// ctrl fields
`define CTRL_SEL_LSB 0
`define CTRL_SPLIT_BIT 4
`define CTRL_HIRES_BIT 5
// outcfg fields: compare enables in 7:0, pin inversion in 15:8
`define OUTCFG_INV_LSB 8
// flag layout: 0 low underflow, 1 high underflow, 5:2 low compare a..d
`define FLAG_LUNF 0
`define FLAG_HUNF 1
`define FLAG_LCMP_LSB 2
// command bit
`define CMD_RESTART_BIT 0

// reset values
`define RST_PER 8'hff
`define RST_CMP 32'h0000_0000

// prescaler tick masks for the free divider count
`define MASK_DIV1 10'h000
`define MASK_DIV2 10'h001
`define MASK_DIV4 10'h003
`define MASK_DIV8 10'h007
`define MASK_DIV64 10'h03f
`define MASK_DIV256 10'h0ff
`define MASK_DIV1024 10'h3ff

`endif

// ---- include/split_pwm_pkg.sv ----
// types shared by the split pwm timer files
// assumes split_pwm_cfg.svh carries all numeric constants
`default_nettype none
package split_pwm_pkg;
  // shared counter clock choices; 1nnn picks event channel nnn
  typedef enum logic [3:0] {
    CLK_OFF = 4'b0000,
    CLK_DIV1 = 4'b0001,
    CLK_DIV2 = 4'b0010,
    CLK_DIV4 = 4'b0011,
    CLK_DIV8 = 4'b0100,
    CLK_DIV64 = 4'b0101,
    CLK_DIV256 = 4'b0110,
    CLK_DIV1024 = 4'b0111
  } clock_source_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ---- design/peripheral_prescaler.sv ----
// divider giving one-cycle tick enables from the peripheral clock
// assumes sel holds a prescaler code; event codes are handled by the caller
`include "split_pwm_cfg.svh"
`default_nettype none
module peripheral_prescaler (
  input wire logic clk, // peripheral clock
  input wire logic rst_b, // async reset, active low
  input wire logic run, // divider counts only while set
  input wire split_pwm_pkg::clock_source_t sel, // chosen division
  output logic tick // one-cycle enable at the chosen rate
);
  import split_pwm_pkg::*;

  logic [9:0] div_cnt; // free divider count
  logic [9:0] mask; // low bits that must be all ones

  // division decode
  always_comb begin
    case (sel)
      CLK_DIV2: mask = `MASK_DIV2;
      CLK_DIV4: mask = `MASK_DIV4;
      CLK_DIV8: mask = `MASK_DIV8;
      CLK_DIV64: mask = `MASK_DIV64;
      CLK_DIV256: mask = `MASK_DIV256;
      CLK_DIV1024: mask = `MASK_DIV1024;
      default: mask = `MASK_DIV1;
    endcase
  end

  assign tick = run && ((div_cnt & mask) == mask);

  // held at zero while stopped so the first period is a full one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 10'h000;
    end else if (!run) begin
      div_cnt <= 10'h000;
    end else begin
      div_cnt <= div_cnt + 10'h001;
    end
  end
endmodule
`default_nettype wire

// ---- design/byte_down_counter.sv ----
// one eight-bit down counter with four compare channels and their waveforms
// assumes tick is a one-cycle enable and load/restart come from the bus side
`default_nettype none
module byte_down_counter (
  input wire logic clk, // peripheral clock
  input wire logic rst_b, // async reset, active low
  input wire logic tick, // count enable
  input wire logic restart, // force count and waveforms to zero
  input wire logic load, // software write of the count
  input wire logic [7:0] load_value, // value written
  input wire logic [7:0] period, // top value reloaded after zero
  input wire logic [31:0] cmp, // four compare bytes, channel 0 lowest
  output logic [7:0] count, // current count
  output logic [3:0] wave, // waveform per channel
  output logic underflow, // pulse: count reached zero by counting
  output logic [3:0] match // pulse: count reached a compare value
);
  logic [7:0] next_count; // count after this cycle
  logic [3:0] next_wave; // waveform after this cycle
  logic changed; // count is updated this cycle
  logic counted; // update caused by a tick alone

  assign changed = restart | load | tick;
  assign counted = tick & ~restart & ~load;

  // write beats restart-free counting; zero reloads the period
  always_comb begin
    if (restart) begin
      next_count = 8'h00;
    end else if (load) begin
      next_count = load_value;
    end else if (tick) begin
      next_count = (count == 8'h00) ? period : count - 8'h01;
    end else begin
      next_count = count;
    end
  end

  // per channel: cleared at zero, set on equality, else held
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_ch
      assign next_wave[ch] = !changed ? wave[ch] :
                             (next_count == 8'h00) ? 1'b0 :
                             (next_count == cmp[ch*8 +: 8]) ? 1'b1 : wave[ch];
    end
  endgenerate

  // state update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 8'h00;
      wave <= 4'h0;
      underflow <= 1'b0;
      match <= 4'h0;
    end else begin
      count <= next_count;
      wave <= next_wave;
      underflow <= counted && count != 8'h00 && next_count == 8'h00;
      for (int i = 0; i < 4; i++) begin
        match[i] <= counted && next_count == cmp[i*8 +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/split_dual_byte_pwm_timer.sv ----
// split-mode timer: two eight-bit down counters, eight pwm pins, apb registers
// assumes apb master on clk, event channels asynchronous, port register on clk
`include "split_pwm_cfg.svh"
`default_nettype none

module split_dual_byte_pwm_timer (
  input wire logic clk, // peripheral clock, 125 mhz
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [7:0] event_in, // event channels, asynchronous
  input wire split_pwm_pkg::byte_t port_out_reg, // port output register
  output logic [7:0] pin_out, // port pin value after override
  output logic irq, // level interrupt
  output logic [1:0] underflow_event, // pulses: 0 low, 1 high
  output logic [3:0] compare_event, // pulses: low compare a..d
  output logic [5:0] dma_req, // dma requests, flag layout
  output logic hires_enable // resolution extension enable
);
  import split_pwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic split_mode; // 1 split, 0 normal
  clock_source_t clock_source_select; // shared clock choice
  logic hires_bit; // hires request
  logic [7:0] cmp_enable; // override enable per pin
  logic [7:0] pin_invert_enable; // inversion per pin
  logic [7:0] lper; // low period
  logic [7:0] hper; // high period
  logic [31:0] lcmp; // low compare values a..d
  logic [31:0] hcmp; // high compare values e..h
  logic [5:0] flags; // sticky status
  logic [5:0] mask; // interrupt mask
  logic [5:0] next_flags; // status after this cycle

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup = psel & ~penable; // first cycle of a transfer
  wire access = psel & penable & pready; // completing edge
  wire sel_ctrl = (paddr == `OFS_CTRL);
  wire sel_outcfg = (paddr == `OFS_OUTCFG);
  wire sel_lper = (paddr == `OFS_LPER);
  wire sel_hper = (paddr == `OFS_HPER);
  wire sel_lcmp = (paddr == `OFS_LCMP);
  wire sel_hcmp = (paddr == `OFS_HCMP);
  wire sel_low_count = (paddr == `OFS_LOW_COUNT);
  wire sel_high_count = (paddr == `OFS_HIGH_COUNT);
  wire sel_flags = (paddr == `OFS_FLAGS);
  wire sel_mask = (paddr == `OFS_MASK);
  wire sel_cmd = (paddr == `OFS_CMD);
  wire mapped = sel_ctrl | sel_outcfg | sel_lper | sel_hper | sel_lcmp | sel_hcmp |
                sel_low_count | sel_high_count | sel_flags | sel_mask | sel_cmd;
  wire wr = access & pwrite & mapped; // write takes effect
  wire restart = wr & sel_cmd & pwdata[`CMD_RESTART_BIT];
  wire [5:0] flag_clear = (wr & sel_flags) ? pwdata[5:0] : 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // clock selection
  logic [7:0] ev_s1; // first synchroniser stage
  logic [7:0] ev_s2; // second synchroniser stage
  logic [7:0] ev_s3; // edge history
  logic presc_tick; // prescaler enable
  wire running = split_mode & (clock_source_select != CLK_OFF);
  wire [7:0] ev_rise = ev_s2 & ~ev_s3; // one pulse per event
  wire ev_tick = ev_rise[clock_source_select[2:0]];
  wire tick = running & (clock_source_select[3] ? ev_tick : presc_tick);

  // event channel synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_s1 <= 8'h00;
      ev_s2 <= 8'h00;
      ev_s3 <= 8'h00;
    end else begin
      ev_s1 <= event_in;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  peripheral_prescaler u_presc (
    .clk(clk),
    .rst_b(rst_b),
    .run(running & ~clock_source_select[3]),
    .sel(clock_source_select),
    .tick(presc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // the two counters share tick, keep own period and compares
  logic [7:0] low_byte_counter; // low count
  logic [7:0] high_byte_counter; // high count
  logic [3:0] lwave; // low waveforms
  logic [3:0] hwave; // high waveforms
  logic lunf; // low underflow pulse
  logic hunf; // high underflow pulse
  logic [3:0] lmatch; // low compare pulses
  logic [3:0] hmatch; // high compare pulses, no event by design

  byte_down_counter u_low (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .restart(restart),
    .load(wr & sel_low_count),
    .load_value(pwdata[7:0]),
    .period(lper),
    .cmp(lcmp),
    .count(low_byte_counter),
    .wave(lwave),
    .underflow(lunf),
    .match(lmatch)
  );

  byte_down_counter u_high (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .restart(restart),
    .load(wr & sel_high_count),
    .load_value(pwdata[7:0]),
    .period(hper),
    .cmp(hcmp),
    .count(high_byte_counter),
    .wave(hwave),
    .underflow(hunf),
    .match(hmatch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status: a set in the clearing cycle wins
  wire [5:0] flag_set = {lmatch, hunf, lunf};
  assign next_flags = (flags & ~flag_clear) | flag_set;

  // pin override: low channels on 3:0, high on 7:4
  wire [7:0] waves = {hwave, lwave};
  wire [7:0] next_pins = (split_mode ? cmp_enable : 8'h00) & (waves ^ pin_invert_enable) |
                         ~(split_mode ? cmp_enable : 8'h00) & port_out_reg;

  // read data selection
  wire [31:0] rdata = sel_ctrl ? {26'h0, hires_bit, split_mode, clock_source_select} :
                      sel_outcfg ? {16'h0, pin_invert_enable, cmp_enable} :
                      sel_lper ? {24'h0, lper} :
                      sel_hper ? {24'h0, hper} :
                      sel_lcmp ? lcmp :
                      sel_hcmp ? hcmp :
                      sel_low_count ? {24'h0, low_byte_counter} :
                      sel_high_count ? {24'h0, high_byte_counter} :
                      sel_flags ? {26'h0, flags} :
                      sel_mask ? {26'h0, mask} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait-free access phase, data captured at setup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? rdata : 32'h0;
    end
  end

  // configuration writes; periods reset to all ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      split_mode <= 1'b0;
      clock_source_select <= CLK_OFF;
      hires_bit <= 1'b0;
      cmp_enable <= 8'h00;
      pin_invert_enable <= 8'h00;
      lper <= `RST_PER;
      hper <= `RST_PER;
      lcmp <= `RST_CMP;
      hcmp <= `RST_CMP;
      mask <= 6'h00;
    end else if (wr) begin
      if (sel_ctrl) begin
        clock_source_select <= clock_source_t'(pwdata[`CTRL_SEL_LSB +: 4]);
        split_mode <= pwdata[`CTRL_SPLIT_BIT];
        hires_bit <= pwdata[`CTRL_HIRES_BIT];
      end
      if (sel_outcfg) begin
        cmp_enable <= pwdata[7:0];
        pin_invert_enable <= pwdata[`OUTCFG_INV_LSB +: 8];
      end
      if (sel_lper) lper <= pwdata[7:0];
      if (sel_hper) hper <= pwdata[7:0];
      if (sel_lcmp) lcmp <= pwdata;
      if (sel_hcmp) hcmp <= pwdata;
      if (sel_mask) mask <= pwdata[5:0];
    end
  end

  // registered outputs and sticky status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= 6'h00;
      irq <= 1'b0;
      pin_out <= 8'h00;
      underflow_event <= 2'b00;
      compare_event <= 4'h0;
      dma_req <= 6'h00;
      hires_enable <= 1'b0;
    end else begin
      flags <= next_flags;
      irq <= |(next_flags & mask);
      pin_out <= next_pins;
      underflow_event <= {hunf, lunf};
      compare_event <= lmatch;
      dma_req <= next_flags;
      hires_enable <= hires_bit & split_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire no_lwr = !(wr & sel_low_count) && !restart;
  wire no_hwr = !(wr & sel_high_count) && !restart;

  low_reload_a: assert property (tick && low_byte_counter == 8'h00 && no_lwr
                                 |=> low_byte_counter == $past(lper))
    else $error("low counter did not reload period");
  high_down_a: assert property (tick && high_byte_counter != 8'h00 && no_hwr
                                |=> high_byte_counter == $past(high_byte_counter) - 8'h01)
    else $error("high counter did not decrement");
  stopped_count_a: assert property (!running && no_lwr |=> $stable(low_byte_counter))
    else $error("counter moved while stopped");
  wave_zero_a: assert property (low_byte_counter == 8'h00 |-> lwave == 4'h0)
    else $error("waveform high at zero");
  low_flag_a: assert property (lmatch[0] |=> flags[`FLAG_LCMP_LSB] ##0 compare_event[0])
    else $error("compare match lost");
  no_high_evt_a: assert property (lmatch == 4'h0 |=> compare_event == 4'h0)
    else $error("compare event without low match");
  pin_override_a: assert property (split_mode && cmp_enable[4]
                                   |=> pin_out[4] == ($past(hwave[0]) ^ $past(pin_invert_enable[4])))
    else $error("pin override wrong");
  normal_pins_a: assert property (!split_mode |=> pin_out == $past(port_out_reg))
    else $error("pins not released in normal mode");
  high_unf_a: assert property (tick && high_byte_counter == 8'h01 && no_hwr |-> ##2 underflow_event[1])
    else $error("high underflow event missing");
endmodule
`default_nettype wire

// ---- tb/event_source.sv ----
// event system stand-in that drives the timer's event channel lines
// assumes the bench calls fire() from its main process; lines idle low
`default_nettype none
module event_source (
  input wire logic clk, // peripheral clock
  output logic [7:0] event_in // event channel lines
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // idle channels sit low, as a quiet event channel does
  initial event_in = 8'h00;

  // raise chosen channels, hold, drop, hold; a long hold models a slow source
  task automatic fire(input logic [7:0] chans, input int hold);
    @(posedge clk);
    event_in <= chans;
    repeat (hold) @(posedge clk);
    event_in <= 8'h00;
    repeat (hold) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench: apb register access, event clocked counting, pins, flags
// assumes event_source model, byte offsets from split_pwm_cfg.svh
`include "split_pwm_cfg.svh"
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import split_pwm_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, hires_enable; // bus and flags
  logic [7:0] paddr; // bus address
  logic [7:0] port_out_reg; // port register value
  logic [7:0] event_in; // from the event model
  logic [7:0] pin_out; // pins seen
  logic [31:0] pwdata, prdata, seed; // bus data and random state
  logic [1:0] underflow_event; // counted pulses
  logic [3:0] compare_event; // counted pulses
  int lu_n, hu_n, ca_n, cb_n; // event pulses seen
  int lu_e, hu_e, ca_e; // event pulses expected
  logic [32:0] note; // oldest read note, taken once
  logic [5:0] dma_req, fl; // requests and their expected copy
  logic [7:0] lc, hc; // expected counts
  logic lw, hw; // expected waveforms a and e
  logic [32:0] expq[$]; // pending read notes {err, data}
  int bad_count, samples_checked;

  split_dual_byte_pwm_timer DUT (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .port_out_reg(port_out_reg), .pin_out(pin_out), .irq(irq),
    .underflow_event(underflow_event), .compare_event(compare_event), .dma_req(dma_req),
    .hires_enable(hires_enable));
  event_source evs (.clk(clk), .event_in(event_in));

  ////////////////////////////////////////////////////////////////////////
  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // xorshift for port register values
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // verdict and end of run
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one apb transfer; held until pready is seen, one idle edge after release
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad_count++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // note the expected answer, then read
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watcher: every read answer is matched against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("[FAIL] t=%0t read without a note, got %h", $time, prdata);
      end else begin
        note = expq.pop_front();
        `CHK({pslverr, prdata}, note)
      end
    end
  end

  // one-cycle event pulses, each seen at exactly one edge
  always @(posedge clk) begin
    lu_n += underflow_event[0];
    hu_n += underflow_event[1];
    ca_n += compare_event[0];
    cb_n += compare_event[1];
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {psel, penable, pwrite, rst_b} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    port_out_reg = 8'h00;
    seed = 32'ha82bfaf5;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`OFS_CTRL, 33'h0);
    rd(`OFS_HPER, {25'h0, `RST_PER});
    rd(`OFS_LCMP, 33'h0);
    rd(8'h2c, 33'h1_0000_0000);
    // clock off: events must not count
    evs.fire(8'hff, 2);
    rd(`OFS_LOW_COUNT, 33'h0);
    wr(`OFS_LPER, 32'h3);
    wr(`OFS_HPER, 32'h5);
    wr(`OFS_LCMP, 32'h2);
    wr(`OFS_HCMP, 32'h4);
    wr(`OFS_LOW_COUNT, 32'h3);
    wr(`OFS_HIGH_COUNT, 32'h5);
    wr(`OFS_OUTCFG, 32'h1011); // pins 0 and 4 driven, pin 4 inverted
    wr(`OFS_MASK, 32'h1); // only low underflow reaches irq
    {lc, hc, lw, hw, fl} = {8'h3, 8'h5, 2'b00, 6'h0};
    for (int i = 0; i < 12; i++) begin
      wr(`OFS_CTRL, 32'h38 | 32'(i % 8));
      seed = xs(seed);
      port_out_reg <= seed[7:0];
      // unselected channel first, then the selected one, fast or slow
      evs.fire(8'h01 << ((i + 3) % 8), 2);
      evs.fire(8'h01 << (i % 8), (i % 2 == 1) ? 5 : 2);
      if (lc == 8'h1) begin
        fl[0] = 1'b1;
        lu_e++;
      end
      if (hc == 8'h1) begin
        fl[1] = 1'b1;
        hu_e++;
      end
      lc = (lc == 8'h0) ? 8'h3 : lc - 8'h1;
      hc = (hc == 8'h0) ? 8'h5 : hc - 8'h1;
      if (lc == 8'h0) begin
        lw = 1'b0;
        fl[5:3] = 3'h7; // compares b..d sit at zero and match there
      end else if (lc == 8'h2) begin
        {lw, fl[2]} = 2'b11;
        ca_e++;
      end
      if (hc == 8'h0) hw = 1'b0;
      else if (hc == 8'h4) hw = 1'b1;
      repeat (6) @(posedge clk);
      `CHK(pin_out, {port_out_reg[7:5], ~hw, port_out_reg[3:1], lw})
      `CHK(hires_enable, 1'b1)
      `CHK(irq, fl[0])
      `CHK(dma_req, fl)
      rd(`OFS_LOW_COUNT, {25'h0, lc});
      rd(`OFS_HIGH_COUNT, {25'h0, hc});
      rd(`OFS_FLAGS, {27'h0, fl});
      if (i == 5) begin
        wr(`OFS_FLAGS, 32'h3f);
        fl = 6'h0;
      end
    end
    // event outputs: underflow from both counters, compare from low only
    `CHK(lu_n, lu_e)
    `CHK(hu_n, hu_e)
    `CHK(ca_n, ca_e)
    `CHK(cb_n, lu_e)
    // back to normal mode: pins follow the port, counters hold
    wr(`OFS_CTRL, 32'h20);
    seed = xs(seed);
    port_out_reg <= seed[7:0];
    evs.fire(8'h01, 2);
    `CHK(pin_out, port_out_reg)
    `CHK(hires_enable, 1'b0)
    rd(`OFS_LOW_COUNT, {25'h0, lc});
    // prescaled clock: a tick every eight cycles, ten of them before the clock goes off
    wr(`OFS_LOW_COUNT, 32'h80);
    wr(`OFS_CTRL, 32'h14);
    repeat (79) @(posedge clk);
    wr(`OFS_CTRL, 32'h10);
    rd(`OFS_LOW_COUNT, 33'h76);
    // restart zeroes both counts; the command reads back zero
    wr(`OFS_CMD, 32'h1);
    rd(`OFS_LOW_COUNT, 33'h0);
    rd(`OFS_HIGH_COUNT, 33'h0);
    rd(`OFS_CMD, 33'h0);
    wr(`OFS_FLAGS, 32'h3f);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(`OFS_FLAGS, 33'h0);
    close_out();
  end
endmodule
`default_nettype wire
